/* hw/field_decoder_pkg.sv */
// Shared constants and types of the instruction field decoder
package field_decoder_pkg;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_BANK      = 8'h00;
  localparam logic [7:0]  ADDR_ACCUM     = 8'h04;
  localparam logic [7:0]  ADDR_TABLE_PTR = 8'h08;
  localparam logic [7:0]  ADDR_TABLE_LAT = 8'h0c;
  localparam logic [7:0]  ADDR_PRODUCT   = 8'h10;
  localparam logic [7:0]  ADDR_FLAGS     = 8'h14;
  localparam logic [7:0]  ADDR_DECODE    = 8'h18;
  localparam logic [3:0]  RST_BANK       = 4'h0;
  localparam logic [7:0]  RST_ACCUM      = 8'h00;
  localparam logic [20:0] RST_TABLE_PTR  = 21'h000000;

  // ----------------------------------------------------------------
  // Field positions and bank mapping
  // ----------------------------------------------------------------
  localparam int          POS_DEST      = 9;
  localparam int          POS_ACCESS    = 8;
  localparam int          POS_CALL_FAST = 8;
  localparam int          POS_RET_FAST  = 0;
  localparam int          POS_TBL_WRITE = 2;
  localparam logic [3:0]  ACCESS_LO     = 4'h0;
  localparam logic [3:0]  ACCESS_HI     = 4'hf;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;

  // ----------------------------------------------------------------
  // Opcode patterns, compared on the defined bits only
  // ----------------------------------------------------------------
  localparam logic [3:0]  OP4_CONT     = 4'hf;
  localparam logic [3:0]  OP4_MOVE     = 4'hc;
  localparam logic [3:0]  OP4_BYTE_LO  = 4'h1;
  localparam logic [3:0]  OP4_BYTE_HI  = 4'h5;
  localparam logic [3:0]  OP4_BIT_LO   = 4'h7;
  localparam logic [3:0]  OP4_BIT_HI   = 4'hb;
  localparam logic [5:0]  OP6_DEC      = 6'h01;
  localparam logic [6:0]  OP7_MUL      = 7'h01;
  localparam logic [7:0]  OP8_LIT      = 8'h0e;
  localparam logic [4:0]  OP5_BRA      = 5'h1a;
  localparam logic [4:0]  OP5_BCOND    = 5'h1c;
  localparam logic [6:0]  OP7_CALL     = 7'h76;
  localparam logic [7:0]  OP8_GOTO     = 8'hef;
  localparam logic [14:0] OP15_RET     = 15'h0009;
  localparam logic [12:0] OP13_TABLE   = 13'h0001;
  localparam logic [1:0]  TBL_NONE     = 2'h0;
  localparam logic [1:0]  TBL_POST_INC = 2'h1;
  localparam logic [1:0]  TBL_POST_DEC = 2'h2;
  localparam logic [1:0]  TBL_PRE_INC  = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {PH_Q1 = 4'b0001, PH_Q2 = 4'b0010, PH_Q3 = 4'b0100, PH_Q4 = 4'b1000} phase_t;
  typedef enum logic [2:0] {PEND_NONE = 3'b001, PEND_MOVE = 3'b010, PEND_JUMP = 3'b100} pend_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
    logic ov;
    logic n;
  } flags_t;

  typedef struct packed {
    logic        valid;
    logic        nop;
    logic        byte_op;
    logic        dest_file;
    logic        bit_op;
    logic [2:0]  bit_pos;
    logic [11:0] file_addr;
    logic        lit_op;
    logic [7:0]  literal;
    logic        mul_op;
    logic        move_op;
    logic [11:0] move_src;
    logic [11:0] move_dst;
    logic        jump;
    logic        cond;
    logic [20:0] target;
    logic        fast_save;
    logic        fast_restore;
    logic        tbl_rd;
    logic        tbl_wr;
    logic [1:0]  tbl_mode;
    logic [20:0] tbl_addr;
  } dec_t;

  typedef struct packed {
    phase_t      phase;
    pend_t       pend;
    logic [11:0] pend_src;
    logic [7:0]  pend_lo;
    logic        pend_call;
    logic        pend_fast;
    logic [3:0]  bank;
    logic [7:0]  accum;
    logic [20:0] table_ptr;
    logic [7:0]  tbllat;
    logic [7:0]  prod_hi;
    logic [7:0]  prod_lo;
    flags_t      flags;
    dec_t        dec;
    logic [31:0] rdata;
  } state_t;

endpackage

/* hw/instruction_field_decoder.sv */
// Operand field decoder of the 8-bit core with its working registers
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module instruction_field_decoder (
  input  wire logic                        I_MCLK,
  input  wire logic                        I_NRST,
  input  wire logic [15:0]                 I_INSTR,
  input  wire logic [20:0]                 I_PC,
  input  wire logic [7:0]                  I_FILE_DATA,
  input  wire logic [7:0]                  I_ALU_RESULT,
  input  wire field_decoder_pkg::flags_t   I_ALU_FLAGS,
  input  wire logic                        I_FLAG_UPDATE,
  input  wire logic                        I_COND_TRUE,
  input  wire logic [7:0]                  I_PM_DATA,
  input  wire logic [7:0]                  I_ADDR,
  input  wire logic [31:0]                 I_WDATA,
  input  wire logic                        I_WR,
  input  wire logic                        I_RD,
  output logic [31:0]                      O_RDATA,
  output field_decoder_pkg::dec_t          O_DEC,
  output field_decoder_pkg::phase_t        O_PHASE,
  output logic [7:0]                       O_ACCUM,
  output logic [20:0]                      O_TABLE_PTR,
  output logic [7:0]                       O_TABLE_LATCH,
  output logic [15:0]                      O_PRODUCT,
  output field_decoder_pkg::flags_t        O_FLAGS
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] operand_addr(input logic banked, input logic [7:0] f, input logic [3:0] bank);
    if (banked)
      return {bank, f};
    return (f < field_decoder_pkg::ACCESS_SPLIT) ? {field_decoder_pkg::ACCESS_LO, f}
                                                 : {field_decoder_pkg::ACCESS_HI, f};
  endfunction

  // Target is the word after the branch plus twice the signed word offset
  function automatic logic [20:0] rel_target(input logic [20:0] pc, input logic [10:0] off);
    return pc + 21'h000002 + {{9{off[10]}}, off, 1'b0};
  endfunction

  field_decoder_pkg::state_t s_q;
  field_decoder_pkg::state_t s_d;
  field_decoder_pkg::dec_t   nd;
  logic [20:0]               tp;
  logic                      flush;
  logic [3:0]                top4;

  assign top4 = I_INSTR[15:12];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.rdata = '0;
    nd        = '0;
    tp        = s_q.table_ptr;
    flush     = 1'b0;

    unique case (s_q.phase)
      field_decoder_pkg::PH_Q1: s_d.phase = field_decoder_pkg::PH_Q2;
      field_decoder_pkg::PH_Q2: s_d.phase = field_decoder_pkg::PH_Q3;
      field_decoder_pkg::PH_Q3: s_d.phase = field_decoder_pkg::PH_Q4;
      field_decoder_pkg::PH_Q4: s_d.phase = field_decoder_pkg::PH_Q1;
    endcase

    if (s_q.phase == field_decoder_pkg::PH_Q4) begin
      // Commit the instruction held during this cycle
      if (s_q.dec.byte_op && !s_q.dec.dest_file)
        s_d.accum = I_ALU_RESULT;
      if (s_q.dec.lit_op)
        s_d.accum = s_q.dec.literal;
      if (s_q.dec.mul_op)
        {s_d.prod_hi, s_d.prod_lo} = 16'(s_q.accum) * 16'(I_FILE_DATA);
      if (I_FLAG_UPDATE)
        s_d.flags = I_ALU_FLAGS;
      if (s_q.dec.tbl_rd)
        s_d.tbllat = I_PM_DATA;
      if (s_q.dec.tbl_rd || s_q.dec.tbl_wr) begin
        unique case (s_q.dec.tbl_mode)
          field_decoder_pkg::TBL_NONE:     tp = s_q.table_ptr;
          field_decoder_pkg::TBL_POST_INC: tp = s_q.table_ptr + 21'h000001;
          field_decoder_pkg::TBL_POST_DEC: tp = s_q.table_ptr - 21'h000001;
          field_decoder_pkg::TBL_PRE_INC:  tp = s_q.table_ptr + 21'h000001;
        endcase
      end
      s_d.table_ptr = tp;
      flush = s_q.dec.jump || I_COND_TRUE;

      // Decode the word for the next cycle; only defined bits are compared
      nd.valid = 1'b1;
      if (flush) begin
        nd.nop   = 1'b1;
        s_d.pend = field_decoder_pkg::PEND_NONE;
      end else if (s_q.pend == field_decoder_pkg::PEND_MOVE && top4 == field_decoder_pkg::OP4_CONT) begin
        nd.move_op  = 1'b1;
        nd.move_src = s_q.pend_src;
        nd.move_dst = I_INSTR[11:0];
        s_d.pend    = field_decoder_pkg::PEND_NONE;
      end else if (s_q.pend == field_decoder_pkg::PEND_JUMP && top4 == field_decoder_pkg::OP4_CONT) begin
        nd.jump      = 1'b1;
        nd.target    = {I_INSTR[11:0], s_q.pend_lo, 1'b0};
        nd.fast_save = s_q.pend_call && s_q.pend_fast;
        s_d.pend     = field_decoder_pkg::PEND_NONE;
      end else begin
        // A stray continuation word or broken pair is dropped here
        s_d.pend = field_decoder_pkg::PEND_NONE;
        if (top4 == field_decoder_pkg::OP4_CONT) begin
          nd.nop = 1'b1;
        end else if ((top4 >= field_decoder_pkg::OP4_BYTE_LO && top4 <= field_decoder_pkg::OP4_BYTE_HI)
                     || I_INSTR[15:10] == field_decoder_pkg::OP6_DEC) begin
          nd.byte_op   = 1'b1;
          nd.dest_file = I_INSTR[field_decoder_pkg::POS_DEST];
          nd.file_addr = operand_addr(I_INSTR[field_decoder_pkg::POS_ACCESS], I_INSTR[7:0], s_q.bank);
        end else if (I_INSTR[15:9] == field_decoder_pkg::OP7_MUL) begin
          nd.mul_op    = 1'b1;
          nd.file_addr = operand_addr(I_INSTR[field_decoder_pkg::POS_ACCESS], I_INSTR[7:0], s_q.bank);
        end else if (top4 >= field_decoder_pkg::OP4_BIT_LO && top4 <= field_decoder_pkg::OP4_BIT_HI) begin
          nd.bit_op    = 1'b1;
          nd.bit_pos   = I_INSTR[11:9];
          nd.file_addr = operand_addr(I_INSTR[field_decoder_pkg::POS_ACCESS], I_INSTR[7:0], s_q.bank);
        end else if (I_INSTR[15:8] == field_decoder_pkg::OP8_LIT) begin
          nd.lit_op  = 1'b1;
          nd.literal = I_INSTR[7:0];
        end else if (top4 == field_decoder_pkg::OP4_MOVE) begin
          s_d.pend     = field_decoder_pkg::PEND_MOVE;
          s_d.pend_src = I_INSTR[11:0];
        end else if (I_INSTR[15:11] == field_decoder_pkg::OP5_BRA) begin
          nd.jump   = 1'b1;
          nd.target = rel_target(I_PC, I_INSTR[10:0]);
        end else if (I_INSTR[15:11] == field_decoder_pkg::OP5_BCOND) begin
          nd.cond   = 1'b1;
          nd.target = rel_target(I_PC, {{3{I_INSTR[7]}}, I_INSTR[7:0]});
        end else if (I_INSTR[15:9] == field_decoder_pkg::OP7_CALL || I_INSTR[15:8] == field_decoder_pkg::OP8_GOTO) begin
          s_d.pend      = field_decoder_pkg::PEND_JUMP;
          s_d.pend_lo   = I_INSTR[7:0];
          s_d.pend_call = (I_INSTR[15:9] == field_decoder_pkg::OP7_CALL);
          s_d.pend_fast = I_INSTR[field_decoder_pkg::POS_CALL_FAST];
        end else if (I_INSTR[15:1] == field_decoder_pkg::OP15_RET) begin
          nd.jump         = 1'b1;
          nd.fast_restore = I_INSTR[field_decoder_pkg::POS_RET_FAST];
        end else if (I_INSTR[15:3] == field_decoder_pkg::OP13_TABLE) begin
          nd.tbl_wr   = I_INSTR[field_decoder_pkg::POS_TBL_WRITE];
          nd.tbl_rd   = !I_INSTR[field_decoder_pkg::POS_TBL_WRITE];
          nd.tbl_mode = I_INSTR[1:0];
          nd.tbl_addr = (I_INSTR[1:0] == field_decoder_pkg::TBL_PRE_INC) ? tp + 21'h000001 : tp;
        end
      end
      s_d.dec = nd;
    end

    // Bus write lands after the commit, so software wins a same-edge clash
    if (I_WR) begin
      unique case (I_ADDR)
        field_decoder_pkg::ADDR_BANK:      s_d.bank   = I_WDATA[3:0];
        field_decoder_pkg::ADDR_ACCUM:     s_d.accum  = I_WDATA[7:0];
        field_decoder_pkg::ADDR_TABLE_PTR: s_d.table_ptr = I_WDATA[20:0];
        field_decoder_pkg::ADDR_TABLE_LAT: s_d.tbllat = I_WDATA[7:0];
        default: ;
      endcase
    end
    if (I_RD) begin
      unique case (I_ADDR)
        field_decoder_pkg::ADDR_BANK:      s_d.rdata = {28'h0000000, s_q.bank};
        field_decoder_pkg::ADDR_ACCUM:     s_d.rdata = {24'h000000, s_q.accum};
        field_decoder_pkg::ADDR_TABLE_PTR: s_d.rdata = {11'h000, s_q.table_ptr};
        field_decoder_pkg::ADDR_TABLE_LAT: s_d.rdata = {24'h000000, s_q.tbllat};
        field_decoder_pkg::ADDR_PRODUCT:   s_d.rdata = {16'h0000, s_q.prod_hi, s_q.prod_lo};
        field_decoder_pkg::ADDR_FLAGS:     s_d.rdata = {27'h0000000, s_q.flags};
        // Status word is 25 bits wide, so seven more zero bits pad it
        field_decoder_pkg::ADDR_DECODE:    s_d.rdata = {7'h00, s_q.pend, s_q.phase, s_q.dec.valid, s_q.dec.nop,
                                                        s_q.dec.dest_file, s_q.dec.bit_pos, s_q.dec.file_addr};
        default:                           s_d.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      s_q <= '{phase: field_decoder_pkg::PH_Q1, pend: field_decoder_pkg::PEND_NONE,
               bank: field_decoder_pkg::RST_BANK, accum: field_decoder_pkg::RST_ACCUM,
               table_ptr: field_decoder_pkg::RST_TABLE_PTR, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign O_RDATA       = s_q.rdata;
  assign O_DEC         = s_q.dec;
  assign O_PHASE       = s_q.phase;
  assign O_ACCUM       = s_q.accum;
  assign O_TABLE_PTR   = s_q.table_ptr;
  assign O_TABLE_LATCH = s_q.tbllat;
  assign O_PRODUCT     = {s_q.prod_hi, s_q.prod_lo};
  assign O_FLAGS       = s_q.flags;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_NRST);

  logic decode_edge;
  logic acc_wr;
  assign decode_edge = (s_q.phase == field_decoder_pkg::PH_Q4) && !s_q.dec.jump && !I_COND_TRUE
                       && s_q.pend == field_decoder_pkg::PEND_NONE;
  assign acc_wr      = I_WR && I_ADDR == field_decoder_pkg::ADDR_ACCUM;

  chk_phase_four_ticks: assert property (
    O_PHASE == field_decoder_pkg::PH_Q1 |-> ##1 O_PHASE == field_decoder_pkg::PH_Q2
      ##1 O_PHASE == field_decoder_pkg::PH_Q3 ##1 O_PHASE == field_decoder_pkg::PH_Q4
      ##1 O_PHASE == field_decoder_pkg::PH_Q1)
    else $error("instruction cycle is not four clocks");

  chk_dest_accum_write: assert property (
    O_PHASE == field_decoder_pkg::PH_Q4 && O_DEC.byte_op && !O_DEC.dest_file && !acc_wr
      |=> O_ACCUM == $past(I_ALU_RESULT))
    else $error("destination 0 did not load the accumulator");

  chk_access_bank_forced: assert property (
    decode_edge && I_INSTR[15:12] == field_decoder_pkg::OP4_BIT_LO && !I_INSTR[8]
      |=> O_DEC.file_addr[11:8] == (($past(I_INSTR[7:0]) < field_decoder_pkg::ACCESS_SPLIT)
                                    ? field_decoder_pkg::ACCESS_LO : field_decoder_pkg::ACCESS_HI))
    else $error("access bank not forced");

  chk_banked_address: assert property (
    decode_edge && I_INSTR[15:12] == field_decoder_pkg::OP4_BIT_LO && I_INSTR[8]
      |=> O_DEC.file_addr == {$past(s_q.bank), $past(I_INSTR[7:0])} && O_DEC.bit_pos == $past(I_INSTR[11:9]))
    else $error("banked address or bit position wrong");

  chk_literal_to_accum: assert property (
    O_PHASE == field_decoder_pkg::PH_Q4 && O_DEC.lit_op && !acc_wr |=> O_ACCUM == $past(O_DEC.literal))
    else $error("literal not loaded");

  chk_lone_cont_nop: assert property (
    decode_edge && I_INSTR[15:12] == field_decoder_pkg::OP4_CONT
      |=> O_DEC.nop && !O_DEC.jump && !O_DEC.move_op)
    else $error("stray continuation word not a no-operation");

  chk_flush_after_jump: assert property (
    O_PHASE == field_decoder_pkg::PH_Q4 && O_DEC.jump |=> O_DEC.nop ##1 O_DEC.nop [*3])
    else $error("no dead cycle after a jump");

  chk_move_pairing: assert property (
    decode_edge && I_INSTR[15:12] == field_decoder_pkg::OP4_MOVE
      ##4 (O_PHASE == field_decoder_pkg::PH_Q4 && !I_COND_TRUE && I_INSTR[15:12] == field_decoder_pkg::OP4_CONT)
      |=> O_DEC.move_op && O_DEC.move_src == $past(I_INSTR[11:0], 5) && O_DEC.move_dst == $past(I_INSTR[11:0]))
    else $error("two-word move addresses wrong");

  chk_table_post_inc: assert property (
    O_PHASE == field_decoder_pkg::PH_Q4 && O_DEC.tbl_rd && O_DEC.tbl_mode == field_decoder_pkg::TBL_POST_INC
      && !I_WR |=> O_TABLE_PTR == $past(O_TABLE_PTR) + 21'h000001 && O_TABLE_LATCH == $past(I_PM_DATA))
    else $error("table read post-increment wrong");

  chk_product_pair: assert property (
    O_PHASE == field_decoder_pkg::PH_Q4 && O_DEC.mul_op |=> O_PRODUCT == $past(O_ACCUM) * $past(I_FILE_DATA))
    else $error("product pair wrong");

  // Flags follow the update strobe only at the commit edge
  chk_flags_capture: assert property (
    O_PHASE == field_decoder_pkg::PH_Q4 && I_FLAG_UPDATE |=> O_FLAGS == $past(I_ALU_FLAGS))
    else $error("status flags not captured");

  // A software write to the latch at the same edge wins, so it is excluded
  chk_table_latch_load: assert property (
    O_PHASE == field_decoder_pkg::PH_Q4 && O_DEC.tbl_rd
      && !(I_WR && I_ADDR == field_decoder_pkg::ADDR_TABLE_LAT)
      |=> O_TABLE_LATCH == $past(I_PM_DATA))
    else $error("table latch not loaded");

  // A true test kills whatever word stands next, even half of a pair
  chk_cond_flush: assert property (
    O_PHASE == field_decoder_pkg::PH_Q4 && I_COND_TRUE |=> O_DEC.nop && O_DEC.valid && !O_DEC.move_op)
    else $error("word after a true test not flushed");

  chk_bit_position: assert property (
    decode_edge && I_INSTR[15:12] >= field_decoder_pkg::OP4_BIT_LO
      && I_INSTR[15:12] <= field_decoder_pkg::OP4_BIT_HI
      |=> O_DEC.bit_op && O_DEC.bit_pos == $past(I_INSTR[11:9]))
    else $error("bit position wrong");

  cov_cond_flush:    cover property (O_PHASE == field_decoder_pkg::PH_Q1 && O_DEC.nop && !O_DEC.jump);
  cov_two_word_move: cover property (O_DEC.move_op);
  cov_fast_call:     cover property (O_DEC.jump && O_DEC.fast_save);
  cov_pre_inc_read:  cover property (O_DEC.tbl_rd && O_DEC.tbl_mode == field_decoder_pkg::TBL_PRE_INC);

endmodule // instruction_field_decoder

/* verification/prog_mem.sv */
// Program memory model feeding one instruction word per instruction cycle
`timescale 1ns/1ps
module prog_mem (
  input  wire logic                      i_clk,
  input  wire logic                      i_nrst,
  input  wire field_decoder_pkg::phase_t i_phase,
  output logic [15:0]                    o_word,
  output logic [20:0]                    o_pc
);
  // ----------------------------------------------------------------
  // Word store and fetch pointer
  // ----------------------------------------------------------------
  logic [15:0] mem [0:15];
  logic [3:0]  idx_q;

  // Advance only after the core took the word at the end of Q4
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst)
      idx_q <= 4'h0;
    else if (i_phase == field_decoder_pkg::PH_Q4)
      idx_q <= idx_q + 4'h1;
  end

  assign o_word = mem[idx_q];
  assign o_pc   = {16'h0000, idx_q, 1'b0};
endmodule // prog_mem

/* verification/tb_instruction_field_decoder.sv */
// Self-checking bench of the instruction field decoder
`timescale 1ns/1ps
module tb_instruction_field_decoder;
  // ----------------------------------------------------------------
  // Stimulus, instances and helpers
  // ----------------------------------------------------------------
  localparam logic [15:0] PROG [0:15] = '{16'h0e55, 16'h2534, 16'h2270, 16'h7c34, 16'hc123, 16'hf456,
    16'hf000, 16'hd7ff, 16'h0e11, 16'h0009, 16'h000b, 16'h000a, 16'h0008, 16'h0334, 16'h7334, 16'he0ff};
  logic                      I_MCLK        = 1'b0;
  logic                      I_NRST        = 1'b0;
  logic [7:0]                I_FILE_DATA   = 8'h03;
  logic [7:0]                I_ALU_RESULT  = 8'ha7;
  field_decoder_pkg::flags_t I_ALU_FLAGS   = 5'h15;
  logic                      I_FLAG_UPDATE = 1'b0;
  logic                      I_COND_TRUE   = 1'b0;
  logic [7:0]                I_PM_DATA     = 8'h5a;
  logic [7:0]                I_ADDR        = 8'h00;
  logic [31:0]               I_WDATA       = 32'h0;
  logic                      I_WR          = 1'b0;
  logic                      I_RD          = 1'b0;
  logic [15:0]               I_INSTR;
  logic [20:0]               I_PC;
  logic [31:0]               O_RDATA;
  field_decoder_pkg::dec_t   O_DEC;
  field_decoder_pkg::phase_t O_PHASE;
  logic [7:0]                O_ACCUM;
  logic [20:0]               O_TABLE_PTR;
  logic [7:0]                O_TABLE_LATCH;
  logic [15:0]               O_PRODUCT;
  field_decoder_pkg::flags_t O_FLAGS;
  int                        miscompares = 0;
  int                        checked     = 0;

  always #2 I_MCLK = ~I_MCLK;

  prog_mem i_mem (.i_clk(I_MCLK), .i_nrst(I_NRST), .i_phase(O_PHASE), .o_word(I_INSTR), .o_pc(I_PC));

  instruction_field_decoder i_dut (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_INSTR(I_INSTR), .I_PC(I_PC),
    .I_FILE_DATA(I_FILE_DATA), .I_ALU_RESULT(I_ALU_RESULT), .I_ALU_FLAGS(I_ALU_FLAGS),
    .I_FLAG_UPDATE(I_FLAG_UPDATE), .I_COND_TRUE(I_COND_TRUE), .I_PM_DATA(I_PM_DATA), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_DEC(O_DEC), .O_PHASE(O_PHASE),
    .O_ACCUM(O_ACCUM), .O_TABLE_PTR(O_TABLE_PTR), .O_TABLE_LATCH(O_TABLE_LATCH), .O_PRODUCT(O_PRODUCT),
    .O_FLAGS(O_FLAGS));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1;
    check(O_RDATA, exp);
  endtask

  // Waits for the next decode edge, bounded so a stuck phase cannot hang
  task automatic step;
    int n;
    n = 0;
    #1;
    while (O_PHASE !== field_decoder_pkg::PH_Q4 && n < 8) begin
      @(posedge I_MCLK);
      #1;
      n++;
    end
    @(posedge I_MCLK);
    #1;
    check(32'(O_PHASE), 32'(field_decoder_pkg::PH_Q1));
  endtask

  task automatic final_report;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    for (int k = 0; k < 16; k++)
      i_mem.mem[k] = PROG[k];
    repeat (3) @(posedge I_MCLK);
    I_NRST <= 1'b1;
    rd_chk(field_decoder_pkg::ADDR_BANK, 32'(field_decoder_pkg::RST_BANK));
    bus_wr(field_decoder_pkg::ADDR_BANK, 32'h3);
    rd_chk(8'hfc, 32'h0);
    step;
    check(32'(O_DEC.lit_op), 32'h1);
    check(32'(O_DEC.literal), 32'h55);
    bus_wr(field_decoder_pkg::ADDR_TABLE_PTR, 32'h1ffffe);
    rd_chk(field_decoder_pkg::ADDR_ACCUM, 32'(field_decoder_pkg::RST_ACCUM));
    step;
    check(32'({O_DEC.byte_op, O_DEC.dest_file}), 32'h2);
    check(32'(O_DEC.file_addr), 32'h334);
    rd_chk(field_decoder_pkg::ADDR_ACCUM, 32'h55);
    step;
    check(32'(O_DEC.dest_file), 32'h1);
    check(32'(O_DEC.file_addr), 32'({field_decoder_pkg::ACCESS_HI, 8'h70}));
    rd_chk(field_decoder_pkg::ADDR_ACCUM, 32'ha7);
    rd_chk(field_decoder_pkg::ADDR_FLAGS, 32'h0);
    I_FLAG_UPDATE <= 1'b1;
    step;
    check(32'({O_DEC.bit_op, O_DEC.bit_pos}), 32'he);
    check(32'(O_DEC.file_addr), 32'({field_decoder_pkg::ACCESS_LO, 8'h34}));
    rd_chk(field_decoder_pkg::ADDR_FLAGS, 32'h15);
    step;
    check(32'({O_DEC.valid, O_DEC.move_op}), 32'h2);
    step;
    check(32'({O_DEC.move_op, O_DEC.move_src, O_DEC.move_dst}), 32'h1123456);
    step;
    check(32'(O_DEC.nop), 32'h1);
    step;
    check(32'({O_DEC.jump, O_DEC.target}), 32'h20000e);
    step;
    check(32'({O_DEC.nop, O_DEC.lit_op}), 32'h2);
    step;
    check(32'({O_DEC.tbl_rd, O_DEC.tbl_mode}), 32'(field_decoder_pkg::TBL_POST_INC) | 32'h4);
    check(32'(O_DEC.tbl_addr), 32'h1ffffe);
    step;
    check(32'({O_DEC.tbl_mode, O_DEC.tbl_addr}), 32'({field_decoder_pkg::TBL_PRE_INC, 21'h0}));
    check(32'(O_TABLE_LATCH), 32'h5a);
    step;
    check(32'({O_DEC.tbl_mode, O_DEC.tbl_addr}), 32'({field_decoder_pkg::TBL_POST_DEC, 21'h0}));
    step;
    check(32'({O_DEC.tbl_mode, O_DEC.tbl_addr}), 32'({field_decoder_pkg::TBL_NONE, 21'h1fffff}));
    step;
    check(32'(O_DEC.mul_op), 32'h1);
    step;
    check(32'(O_PRODUCT), 32'(16'ha7 * 16'h03));
    check(32'(O_TABLE_PTR), 32'h1fffff);
    check(32'({O_DEC.bit_op, O_DEC.bit_pos}), 32'h9);
    check(32'(O_DEC.file_addr), 32'h334);
    step;
    check(32'({O_DEC.cond, O_DEC.target}), 32'h20001e);
    I_COND_TRUE <= 1'b1;
    step;
    I_COND_TRUE <= 1'b0;
    check(32'({O_DEC.nop, O_DEC.lit_op}), 32'h2);
    final_report;
  end

  // Run needs about 70 clocks; this span leaves ample margin
  initial begin
    #20000;
    miscompares++;
    final_report;
  end
endmodule // tb_instruction_field_decoder
